/* File: core/ccms_pkg.sv */
// Constants, offsets and state type of the clock source mode select block.
// Assumes one 100 MHz core clock and a byte-wide register port behind the serial control port.
// Behaviour
// - Loop power code 00b runs the loop powered on.
// - Loop power code 01b powers the loop down.
// - Source bit 1 set selects the internal oscillator.
// - Source bit 1 clear selects the external clock input.
// - Source bit 0 clear routes the source through the pre-divider.
// - Source bit 0 set bypasses the pre-divider.
// - Loop control bit 7 sets detector polarity; 1 inverts the tuning slope.
// - Reset default: loop down, pre-divider code 000b in use, external input.
// - With external input selected the internal oscillator stays powered off.
// - Settings can be saved to nonvolatile storage and restored at reset.
package ccms_pkg;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NREG   = 5;

  // Register byte offsets
  localparam logic [9:0] OFF_LOOP   = 10'h010;
  localparam logic [9:0] OFF_CAL    = 10'h018;
  localparam logic [9:0] OFF_REF    = 10'h01C;
  localparam logic [9:0] OFF_PREDIV = 10'h1E0;
  localparam logic [9:0] OFF_SRC    = 10'h1E1;
  localparam logic [9:0] OFF_XFER   = 10'h232;
  localparam logic [9:0] OFF_NVCTL  = 10'h0B3;

  // Slot of each staged register in the register arrays
  localparam logic [2:0] IDX_LOOP   = 3'h0;
  localparam logic [2:0] IDX_CAL    = 3'h1;
  localparam logic [2:0] IDX_REF    = 3'h2;
  localparam logic [2:0] IDX_PREDIV = 3'h3;
  localparam logic [2:0] IDX_SRC    = 3'h4;
  localparam logic [2:0] IDX_NONE   = 3'h7;

  // Field positions
  localparam int unsigned LOOP_PWR_LSB = 0;
  localparam int unsigned LOOP_POL_BIT = 7;
  localparam int unsigned CAL_BIT      = 0;
  localparam int unsigned SRC_BYP_BIT  = 0;
  localparam int unsigned SRC_INT_BIT  = 1;
  localparam int unsigned XFER_BIT     = 0;
  localparam int unsigned NV_SAVE_BIT  = 0;
  localparam int unsigned NV_VALID_BIT = 1;

  // Loop power codes
  localparam logic [1:0] PWR_ON   = 2'h0;
  localparam logic [1:0] PWR_DOWN = 2'h1;

  // Values after reset
  localparam logic [7:0] RST_LOOP = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;

  typedef struct packed {
    logic [NREG-1:0][7:0] stg;      // Staging copies
    logic [NREG-1:0][7:0] act;      // Applied settings
    logic [NREG-1:0][7:0] nv;       // Nonvolatile image
    logic                 nv_valid; // Image holds saved settings
    logic [7:0]           rdata;
    logic                 rvalid;
    logic                 cal_start;
  } ccms_state_t;
endpackage : ccms_pkg

/* File: core/ccms_top.sv */
// Clock source mode select: staged configuration registers and mode outputs.
// Assumes register accesses arrive as single-cycle strobes synchronous to i_core_clk.
`timescale 1ns/10ps
module ccms_top #(
  parameter int unsigned ADDR_W = ccms_pkg::ADDR_W
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_resetn,
  input  wire logic [ADDR_W-1:0] i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [7:0]        o_reg_rdata,
  output logic                   o_reg_rvalid,
  output logic                   o_loop_on,
  output logic                   o_loop_powerdown,
  output logic                   o_det_invert,
  output logic                   o_src_internal,
  output logic                   o_osc_on,
  output logic                   o_prediv_bypass,
  output logic      [2:0]        o_prediv_div,
  output logic      [2:0]        o_ref_enable,
  output logic                   o_cal_start
);

  // Refuse an address port too narrow for the map
  if (ADDR_W < ccms_pkg::ADDR_W) begin : g_chk
    $error("ccms_top: ADDR_W too small for register map");
  end

  // Map a byte offset to its staging slot
  function automatic logic [2:0] slot_of(input logic [ADDR_W-1:0] a);
    logic [2:0] s;
    s = ccms_pkg::IDX_NONE;
    if (a == ADDR_W'(ccms_pkg::OFF_LOOP))   s = ccms_pkg::IDX_LOOP;
    if (a == ADDR_W'(ccms_pkg::OFF_CAL))    s = ccms_pkg::IDX_CAL;
    if (a == ADDR_W'(ccms_pkg::OFF_REF))    s = ccms_pkg::IDX_REF;
    if (a == ADDR_W'(ccms_pkg::OFF_PREDIV)) s = ccms_pkg::IDX_PREDIV;
    if (a == ADDR_W'(ccms_pkg::OFF_SRC))    s = ccms_pkg::IDX_SRC;
    return s;
  endfunction : slot_of

  // Pre-divider code to ratio, 000b is two, top code clamps to six
  function automatic logic [2:0] div_of(input logic [2:0] code);
    logic [2:0] d;
    d = code;
    if (code == 3'h0) d = 3'h2;
    if (code == 3'h7) d = 3'h6;
    return d;
  endfunction : div_of

  ccms_pkg::ccms_state_t s_q;
  ccms_pkg::ccms_state_t s_d;
  logic [2:0]            wr_slot;
  logic [2:0]            rd_slot;
  logic                  xfer_hit;
  logic                  nv_save_hit;

  assign wr_slot     = slot_of(i_reg_addr);
  assign rd_slot     = wr_slot;
  assign xfer_hit    = i_reg_wr && (i_reg_addr == ADDR_W'(ccms_pkg::OFF_XFER))
                       && i_reg_wdata[ccms_pkg::XFER_BIT];
  assign nv_save_hit = i_reg_wr && (i_reg_addr == ADDR_W'(ccms_pkg::OFF_NVCTL))
                       && i_reg_wdata[ccms_pkg::NV_SAVE_BIT];

  // Next state: staging writes, transfer, save and read-back
  always_comb begin
    s_d           = s_q;
    s_d.rvalid    = i_reg_rd;
    s_d.cal_start = 1'b0;
    if (i_reg_wr && wr_slot != ccms_pkg::IDX_NONE) begin
      s_d.stg[wr_slot] = i_reg_wdata;
    end
    if (xfer_hit) begin
      s_d.act = s_q.stg;
      // Calibration starts on a 0 to 1 step of the applied bit
      s_d.cal_start = s_q.stg[ccms_pkg::IDX_CAL][ccms_pkg::CAL_BIT]
                      && !s_q.act[ccms_pkg::IDX_CAL][ccms_pkg::CAL_BIT];
    end
    if (nv_save_hit) begin
      s_d.nv       = s_q.act;
      s_d.nv_valid = 1'b1;
    end
    if (i_reg_rd) begin
      s_d.rdata = ccms_pkg::RST_ZERO;
      if (rd_slot != ccms_pkg::IDX_NONE) begin
        s_d.rdata = s_q.stg[rd_slot];
      end
      if (i_reg_addr == ADDR_W'(ccms_pkg::OFF_NVCTL)) begin
        s_d.rdata[ccms_pkg::NV_VALID_BIT] = s_q.nv_valid;
      end
    end
  end

  // State register; reset restores saved image or defaults, keeps storage
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      s_q.nv        <= s_q.nv;
      s_q.nv_valid  <= s_q.nv_valid;
      s_q.rdata     <= ccms_pkg::RST_ZERO;
      s_q.rvalid    <= 1'b0;
      s_q.cal_start <= 1'b0;
      if (s_q.nv_valid) begin
        s_q.stg <= s_q.nv;
        s_q.act <= s_q.nv;
      end else begin
        s_q.stg <= '0;
        s_q.act <= '0;
        s_q.stg[ccms_pkg::IDX_LOOP] <= ccms_pkg::RST_LOOP;
        s_q.act[ccms_pkg::IDX_LOOP] <= ccms_pkg::RST_LOOP;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // Mode outputs decoded from applied settings
  logic [7:0] loop_q;
  logic [7:0] src_q;
  assign loop_q           = s_q.act[ccms_pkg::IDX_LOOP];
  assign src_q            = s_q.act[ccms_pkg::IDX_SRC];
  assign o_loop_on        = loop_q[ccms_pkg::LOOP_PWR_LSB +: 2] == ccms_pkg::PWR_ON;
  assign o_loop_powerdown = loop_q[ccms_pkg::LOOP_PWR_LSB +: 2] == ccms_pkg::PWR_DOWN;
  assign o_det_invert     = loop_q[ccms_pkg::LOOP_POL_BIT];
  assign o_src_internal   = src_q[ccms_pkg::SRC_INT_BIT];
  assign o_osc_on         = o_src_internal && o_loop_on;
  assign o_prediv_bypass  = src_q[ccms_pkg::SRC_BYP_BIT];
  assign o_prediv_div     = div_of(s_q.act[ccms_pkg::IDX_PREDIV][2:0]);
  assign o_ref_enable     = s_q.act[ccms_pkg::IDX_REF][2:0];
  assign o_cal_start      = s_q.cal_start;
  assign o_reg_rdata      = s_q.rdata;
  assign o_reg_rvalid     = s_q.rvalid;

  // Checks on the applied configuration
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_xfer;
    xfer_hit;
  endsequence
  sequence s_stage_down;
    s_q.stg[ccms_pkg::IDX_LOOP][1:0] == ccms_pkg::PWR_DOWN;
  endsequence

  property p_loop_on;
    s_xfer |=> o_loop_on == ($past(s_q.stg[ccms_pkg::IDX_LOOP][1:0]) == 2'h0);
  endproperty
  a_loop_on: assert property (p_loop_on) else $error("loop power not applied");

  property p_pwrdown;
    s_xfer ##0 s_stage_down |=> o_loop_powerdown && !o_loop_on;
  endproperty
  a_pwrdown: assert property (p_pwrdown) else $error("loop not powered down");

  property p_src;
    s_xfer |=> o_src_internal == $past(s_q.stg[ccms_pkg::IDX_SRC][1]);
  endproperty
  a_src: assert property (p_src) else $error("source select wrong");

  property p_bypass_held;
    $past(i_resetn) && $changed(o_prediv_bypass) |-> $past(xfer_hit);
  endproperty
  a_bypass_held: assert property (p_bypass_held) else $error("bypass moved unstrobed");

  property p_bypass;
    s_xfer |=> o_prediv_bypass == $past(s_q.stg[ccms_pkg::IDX_SRC][0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass select wrong");

  property p_div;
    (o_prediv_div >= 3'h1) && (o_prediv_div <= 3'h6)
    && ((s_q.act[ccms_pkg::IDX_PREDIV][2:0] == 3'h0) -> (o_prediv_div == 3'h2));
  endproperty
  a_div: assert property (p_div) else $error("pre-divider ratio out of range");

  property p_pol;
    $past(i_resetn) && $changed(o_det_invert) |->
      $past(xfer_hit) && o_det_invert == $past(s_q.stg[0][7]);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity change wrong");

  property p_reset;
    $rose(i_resetn) |-> s_q.nv_valid
      || (o_loop_powerdown && !o_prediv_bypass && !o_src_internal && o_prediv_div == 3'h2);
  endproperty
  a_reset: assert property (p_reset) else $error("reset defaults wrong");

  property p_osc;
    !o_src_internal |-> !o_osc_on;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator on with external input");

  property p_nv;
    nv_save_hit |=> s_q.nv_valid && s_q.nv == $past(s_q.act);
  endproperty
  a_nv: assert property (p_nv) else $error("settings not saved");

  property p_cal;
    s_xfer ##0 (s_q.stg[1][0] && !s_q.act[1][0]) |=> o_cal_start ##1 !o_cal_start;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration pulse wrong");

  // Calibration start is a single-cycle pulse
  property p_cal_single;
    o_cal_start |=> !o_cal_start;
  endproperty
  a_cal_single: assert property (p_cal_single) else $error("calibration pulse long");

  // Applied settings move only on a transfer strobe, reset aside
  property p_act_held;
    $past(i_resetn) && !$past(xfer_hit) |-> $stable(s_q.act);
  endproperty
  a_act_held: assert property (p_act_held) else $error("settings moved unstrobed");

  // Reads of staged registers answer next cycle with the staged byte
  property p_rd_stage;
    i_reg_rd && (rd_slot != ccms_pkg::IDX_NONE) |=>
      o_reg_rvalid && (o_reg_rdata == $past(s_q.stg[rd_slot]));
  endproperty
  a_rd_stage: assert property (p_rd_stage) else $error("read-back not staged byte");

  // Reference enable follows the transfer
  property p_ref;
    s_xfer |=> o_ref_enable == $past(s_q.stg[ccms_pkg::IDX_REF][2:0]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference enable not applied");

endmodule : ccms_top

/* File: tb/ccms_ext_src.sv */
// External clock source model feeding the clock input pair.
// Assumes the block's source select output; the clock runs only while selected.
`timescale 1ns/10ps
module ccms_ext_src #(
  parameter int unsigned HALF_NS = 1
) (
  input  wire logic i_src_internal,
  output logic      o_ext_clk
);
  // Stands low while deselected; 500 MHz stays below the divider input limit
  initial begin
    o_ext_clk = 1'b0;
    forever begin
      #(HALF_NS);
      // Unknown select before reset counts as deselected
      o_ext_clk = (i_src_internal === 1'b0) ? ~o_ext_clk : 1'b0;
    end
  end
endmodule : ccms_ext_src

/* File: tb/tb_ccms_top.sv */
// Self-checking bench for the clock source mode select block.
// Assumes the design package and the external source model are compiled first.
`timescale 1ns/10ps
module tb_ccms_top;
  logic       i_core_clk  = 1'b0;
  logic       i_resetn    = 1'b0;
  logic [9:0] i_reg_addr  = 10'h000;
  logic [7:0] i_reg_wdata = 8'h00;
  logic       i_reg_wr    = 1'b0;
  logic       i_reg_rd    = 1'b0;
  logic [7:0] o_reg_rdata;
  logic [2:0] o_prediv_div, o_ref_enable;
  logic       o_reg_rvalid, o_loop_on, o_loop_powerdown, o_det_invert, o_src_internal;
  logic       o_osc_on, o_prediv_bypass, o_cal_start, ext_clk;
  int         error_cnt   = 0;
  int         checks_done = 0;

  // Core clock, 100 MHz
  always #5 i_core_clk = ~i_core_clk;

  ccms_top ccms_top_inst (.i_core_clk, .i_resetn, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .o_loop_on, .o_loop_powerdown, .o_det_invert,
    .o_src_internal, .o_osc_on, .o_prediv_bypass, .o_prediv_div, .o_ref_enable,
    .o_cal_start);
  ccms_ext_src ccms_ext_src_inst (.i_src_internal(o_src_internal), .o_ext_clk(ext_clk));

  // Compare and count
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One-cycle write strobe launched at the falling edge
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_reg_addr  = a;
    i_reg_wdata = d;
    i_reg_wr    = 1'b1;
    @(negedge i_core_clk);
    i_reg_wr = 1'b0;
  endtask : wr

  // Transfer strobe; outputs are settled when it returns
  task automatic xfer();
    wr(ccms_pkg::OFF_XFER, 8'h01);
  endtask : xfer

  // Read and compare the returned byte
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(negedge i_core_clk);
    i_reg_addr = a;
    i_reg_rd   = 1'b1;
    @(negedge i_core_clk);
    i_reg_rd = 1'b0;
    chk("rvalid", 8'(o_reg_rvalid), 8'h01);
    chk("rdata", o_reg_rdata, exp);
  endtask : rd

  // Power-up mode: distribution only
  task automatic t_reset();
    chk("pdown", 8'(o_loop_powerdown), 8'h01);
    chk("loop_on", 8'(o_loop_on), 8'h00);
    chk("src_int", 8'(o_src_internal), 8'h00);
    chk("bypass", 8'(o_prediv_bypass), 8'h00);
    chk("div", 8'(o_prediv_div), 8'h02);
  endtask : t_reset

  // Staged loop power, applied only by transfer
  task automatic t_loop();
    wr(ccms_pkg::OFF_LOOP, 8'h00);
    chk("loop_on", 8'(o_loop_on), 8'h00);
    rd(ccms_pkg::OFF_LOOP, 8'h00);
    xfer();
    chk("loop_on", 8'(o_loop_on), 8'h01);
    chk("pdown", 8'(o_loop_powerdown), 8'h00);
  endtask : t_loop

  // Source and bypass selection both ways
  task automatic t_src();
    wr(ccms_pkg::OFF_SRC, 8'h03);
    xfer();
    chk("src_int", 8'(o_src_internal), 8'h01);
    chk("bypass", 8'(o_prediv_bypass), 8'h01);
    chk("osc_on", 8'(o_osc_on), 8'h01);
    chk("ext_clk", 8'(ext_clk), 8'h00);
    wr(ccms_pkg::OFF_SRC, 8'h00);
    xfer();
    chk("src_int", 8'(o_src_internal), 8'h00);
    chk("bypass", 8'(o_prediv_bypass), 8'h00);
    chk("osc_on", 8'(o_osc_on), 8'h00);
  endtask : t_src

  // Every pre-divider code
  task automatic t_prediv();
    for (int i = 0; i < 8; i++) begin
      wr(ccms_pkg::OFF_PREDIV, 8'(i));
      xfer();
      chk("div", 8'(o_prediv_div), (i == 0) ? 8'h02 : (i == 7) ? 8'h06 : 8'(i));
    end
  endtask : t_prediv

  // Detector polarity, then loop power-down
  task automatic t_pol();
    wr(ccms_pkg::OFF_LOOP, 8'h80);
    xfer();
    chk("det_inv", 8'(o_det_invert), 8'h01);
    wr(ccms_pkg::OFF_LOOP, 8'h02);
    xfer();
    chk("loop_on", 8'(o_loop_on), 8'h00);
    chk("pdown", 8'(o_loop_powerdown), 8'h00);
    wr(ccms_pkg::OFF_LOOP, 8'h01);
    xfer();
    chk("det_inv", 8'(o_det_invert), 8'h00);
    chk("pdown", 8'(o_loop_powerdown), 8'h01);
    chk("loop_on", 8'(o_loop_on), 8'h00);
  endtask : t_pol

  // Calibration start, repeat refused, restart after clear
  task automatic t_cal();
    wr(ccms_pkg::OFF_CAL, 8'h01);
    xfer();
    chk("cal", 8'(o_cal_start), 8'h01);
    @(negedge i_core_clk);
    chk("cal", 8'(o_cal_start), 8'h00);
    xfer();
    chk("cal", 8'(o_cal_start), 8'h00);
    wr(ccms_pkg::OFF_CAL, 8'h00);
    xfer();
    wr(ccms_pkg::OFF_CAL, 8'h01);
    xfer();
    chk("cal", 8'(o_cal_start), 8'h01);
  endtask : t_cal

  // Reference enable, unmapped and strobe reads
  task automatic t_ref();
    wr(ccms_pkg::OFF_REF, 8'h05);
    xfer();
    chk("ref_en", 8'(o_ref_enable), 8'h05);
    rd(10'h3FF, 8'h00);
    rd(ccms_pkg::OFF_XFER, 8'h00);
  endtask : t_ref

  // Save settings, reset, expect them restored
  task automatic t_nv();
    wr(ccms_pkg::OFF_NVCTL, 8'h01);
    rd(ccms_pkg::OFF_NVCTL, 8'h02);
    i_resetn = 1'b0;
    repeat (2) @(negedge i_core_clk);
    i_resetn = 1'b1;
    @(negedge i_core_clk);
    chk("ref_en", 8'(o_ref_enable), 8'h05);
    chk("div", 8'(o_prediv_div), 8'h06);
  endtask : t_nv

  // Report counts and verdict
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    repeat (16) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_resetn = 1'b1;
    t_reset();
    t_loop();
    t_src();
    t_prediv();
    t_pol();
    t_cal();
    t_ref();
    t_nv();
    give_verdict();
  end
endmodule : tb_ccms_top
